// ===== rsc_reset_cause.sv
// reset source merging, reset-cause register and wishbone slave
// assumes rst_i is the power-on reset and all event inputs are
// single-cycle pulses synchronous to clk_i
//
// Local design decisions: the Wishbone register port and the address map.
`include "rsc_regs.svh"
`default_nettype none
module rsc_reset_cause #(
  parameter int unsigned POWERUP_TIMER_STEP_CYC = `RSC_POWERUP_TIMER_STEP_CYC
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // supply and pin
  input wire logic supply_ok_i,
  input wire logic external_reset_pin_n_i,
  // core events
  input wire logic reset_instr_i,
  input wire logic wdt_timeout_i,
  input wire logic sleep_mode_i,
  input wire logic idle_mode_i,
  input wire logic power_save_sleep_i,
  input wire logic power_save_idle_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic trap_busy_i,
  input wire logic [3:0] trap_busy_level_i,
  input wire logic trap_new_i,
  input wire logic [3:0] trap_new_level_i,
  input wire logic fetch_valid_i,
  input wire logic [23:0] fetch_opcode_i,
  input wire logic wreg_write_i,
  input wire logic [3:0] wreg_write_idx_i,
  input wire logic ptr_use_i,
  input wire logic [3:0] ptr_use_idx_i,
  input wire logic program_flow_change_i,
  input wire logic vector_flow_change_i,
  input wire logic target_restricted_i,
  input wire logic pps_write_i,
  input wire logic [15:0] pps_wdata_i,
  input wire logic [15:0] pps_value_i,
  // clock control
  input wire logic [2:0] initial_clock_select_i,
  input wire logic clock_ready_i,
  // reset outputs
  output logic system_reset_n_o,
  output logic cold_reset_o,
  output logic [2:0] current_clock_select_o,
  output logic wake_o,
  output logic fetch_start_o,
  output logic [23:0] start_addr_o
);
  import rsc_pkg::*;
  rsc_top_type st_ff;
  rsc_top_type nxt_st;
  logic bor_hold;
  logic bor_drop;
  logic pin_reset;
  logic running;
  logic ev_swr;
  logic ev_wdt;
  logic ev_trap;
  logic ev_cm;
  logic ev_iop;
  logic ev_uwr;
  logic ev_sec;
  logic warm_any;
  logic bus_go;
  logic [7:0] bus_addr;
  logic [15:0] wmask;
  logic [14:0] wreg_set;

  rsc_powerup_timer #(
    .POWERUP_TIMER_STEP_CYC(POWERUP_TIMER_STEP_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .supply_ok_i(supply_ok_i),
    .powerup_delay_select_i(st_ff.powerup_timer_sel),
    .hold_o(bor_hold),
    .drop_o(bor_drop)
  );

  rsc_pin_filter u_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .external_reset_pin_n_i(external_reset_pin_n_i),
    .pin_reset_o(pin_reset)
  );

  // per-register write decode for the init marks; the stack pointer
  // is never tracked so it is not part of this vector
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi++) begin : g_wreg
      assign wreg_set[gi] = wreg_write_i && (wreg_write_idx_i == 4'(gi));
    end
  endgenerate

  assign running = st_ff.system_reset_n_n;
  assign ev_swr = running && reset_instr_i;
  // a timeout while asleep only wakes the core
  assign ev_wdt = running && wdt_timeout_i && !sleep_mode_i && !idle_mode_i;
  assign ev_trap = running && trap_busy_i && trap_new_i
    && (trap_new_level_i >= `RSC_HARD_TRAP_LO) && (trap_new_level_i <= `RSC_HARD_TRAP_HI)
    && (trap_new_level_i < trap_busy_level_i);
  // a legal write reloads the shadow, so the compare skips that cycle
  assign ev_cm = running && !pps_write_i && (pps_value_i != st_ff.pps_shadow);
  assign ev_iop = running && fetch_valid_i && (fetch_opcode_i[23:16] == `RSC_ILLEGAL_OP);
  assign ev_uwr = running && ptr_use_i && (ptr_use_idx_i != 4'(`RSC_WREG_SP))
    && !st_ff.wreg_init[ptr_use_idx_i[3:0] == 4'hf ? 4'h0 : ptr_use_idx_i];
  assign ev_sec = running && (program_flow_change_i || vector_flow_change_i)
    && target_restricted_i;
  assign warm_any = ev_swr || ev_wdt || ev_trap || ev_cm || ev_iop || ev_uwr || ev_sec;

  assign bus_go = wb_cyc_i && wb_stb_i;
  assign bus_addr = {wb_adr_i[7:2], 2'b00};
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `RSC_CAUSE_WMASK;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = bus_go && !st_ff.ack;
    nxt_st.wake = running && wdt_timeout_i && (sleep_mode_i || idle_mode_i);
    nxt_st.fetch_start = 1'b0;
    // read data is captured with ack, from the state before this access
    nxt_st.rdata = 32'h0;
    if (bus_addr == `RSC_CAUSE_ADDR) begin
      nxt_st.rdata = {16'h0, st_ff.cause};
    end else if (bus_addr == `RSC_CTRL_ADDR) begin
      nxt_st.rdata = {29'h0, st_ff.powerup_timer_sel};
    end else if (bus_addr == `RSC_STAT_ADDR) begin
      nxt_st.rdata = {25'h0, st_ff.clksel, pin_reset, bor_hold, st_ff.system_reset_n_n, supply_ok_i};
    end
    // the write lands on the edge where ack is seen high; a flag write
    // only stores the value and never feeds the reset merge
    if (bus_go && st_ff.ack && wb_we_i) begin
      if (bus_addr == `RSC_CAUSE_ADDR) begin
        nxt_st.cause = (st_ff.cause & ~wmask) | (wb_dat_i[15:0] & wmask);
      end else if ((bus_addr == `RSC_CTRL_ADDR) && wb_sel_i[0]) begin
        nxt_st.powerup_timer_sel = wb_dat_i[2:0];
      end
    end
    // cold clears first, then every event sets so a set beats any clear
    if (bor_drop) begin
      nxt_st.cause = (nxt_st.cause & ~`RSC_COLD_CLR);
    end
    if (power_save_sleep_i || power_save_idle_i || watchdog_clear_instruction_i) begin
      nxt_st.cause[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    if (bor_drop) begin
      nxt_st.cause[`RSC_BIT_BOR] = 1'b1;
    end
    if (pin_reset) begin
      nxt_st.cause[`RSC_BIT_PIN_RESET_FLAG] = 1'b1;
    end
    if (ev_swr) begin
      nxt_st.cause[`RSC_BIT_SWR] = 1'b1;
    end
    if (ev_wdt) begin
      nxt_st.cause[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    end
    if (power_save_sleep_i) begin
      nxt_st.cause[`RSC_BIT_SLEEP] = 1'b1;
    end
    if (power_save_idle_i) begin
      nxt_st.cause[`RSC_BIT_IDLE] = 1'b1;
    end
    if (ev_trap) begin
      nxt_st.cause[`RSC_BIT_TRAP] = 1'b1;
    end
    if (ev_cm) begin
      nxt_st.cause[`RSC_BIT_CM] = 1'b1;
    end
    if (ev_iop || ev_uwr || ev_sec) begin
      nxt_st.cause[`RSC_BIT_ILL] = 1'b1;
    end
    // warm sources last one cycle, so release is the next cycle
    nxt_st.system_reset_n_n = !(bor_hold || pin_reset || warm_any);
    nxt_st.cold = bor_hold;
    if (bor_hold) begin
      nxt_st.clksel = initial_clock_select_i;
    end
    if (!st_ff.system_reset_n_n) begin
      nxt_st.wreg_init = 15'h0;
      nxt_st.started = 1'b0;
      nxt_st.pps_shadow = pps_value_i;
    end else begin
      nxt_st.wreg_init = st_ff.wreg_init | wreg_set;
      if (pps_write_i) begin
        nxt_st.pps_shadow = pps_wdata_i;
      end
      if (!st_ff.started && clock_ready_i) begin
        nxt_st.started = 1'b1;
        nxt_st.fetch_start = 1'b1;
      end
    end
    nxt_st.start_addr = `RSC_RESET_ADDR;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{ack: 1'b0, rdata: 32'h0, cause: `RSC_CAUSE_RST,
                 powerup_timer_sel: `RSC_POWERUP_TIMER_SEL_RST, system_reset_n_n: 1'b0, cold: 1'b1, wake: 1'b0,
                 clksel: `RSC_CLKSEL_RST, started: 1'b0, fetch_start: 1'b0,
                 start_addr: `RSC_RESET_ADDR, wreg_init: 15'h0, pps_shadow: 16'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign system_reset_n_o = st_ff.system_reset_n_n;
  assign cold_reset_o = st_ff.cold;
  assign current_clock_select_o = st_ff.clksel;
  assign wake_o = st_ff.wake;
  assign fetch_start_o = st_ff.fetch_start;
  assign start_addr_o = st_ff.start_addr;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_warm_hit(bit_ok);
    !system_reset_n_o && bit_ok;
  endsequence

  a_swr_reset: assert property (ev_swr |=> s_warm_hit(st_ff.cause[6]))
    else $error("software reset did not reset or flag");
  a_wdt_reset: assert property (ev_wdt |=> s_warm_hit(st_ff.cause[4]))
    else $error("watchdog reset did not reset or flag");
  a_wdt_wake: assert property (running && wdt_timeout_i && (sleep_mode_i || idle_mode_i)
    && !bor_hold && !pin_reset && !warm_any |=> wake_o && system_reset_n_o)
    else $error("watchdog in sleep did not wake cleanly");
  a_trap_conflict: assert property (ev_trap |=> s_warm_hit(st_ff.cause[15]))
    else $error("trap conflict missed");
  a_cfg_mismatch: assert property (ev_cm |=> s_warm_hit(st_ff.cause[9]))
    else $error("configuration mismatch missed");
  a_illegal_cond: assert property ((ev_iop || ev_uwr || ev_sec) |=> s_warm_hit(st_ff.cause[14]))
    else $error("illegal condition missed");
  a_hold_brownout: assert property (!supply_ok_i |-> ##2 !system_reset_n_o)
    else $error("reset released during brown-out");
  a_flag_write_quiet: assert property (system_reset_n_o && !bor_hold && !pin_reset
    && !warm_any |=> system_reset_n_o)
    else $error("reset without a source");
  a_bor_flag: assert property (bor_drop |=> st_ff.cause[1] && cold_reset_o)
    else $error("brown-out flag not set");
  a_fetch_once: assert property (fetch_start_o |=> !fetch_start_o [*2])
    else $error("fetch start repeated");
endmodule : rsc_reset_cause
`default_nettype wire

// ===== rsc_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 25 MHz system clock; included by the three design module files, not by the package
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_CAUSE_ADDR 8'h00
`define RSC_CTRL_ADDR 8'h04
`define RSC_STAT_ADDR 8'h08
`define RSC_BIT_POR 0
`define RSC_BIT_BOR 1
`define RSC_BIT_IDLE 2
`define RSC_BIT_SLEEP 3
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RSC_BIT_SWR 6
`define RSC_BIT_PIN_RESET_FLAG 7
`define RSC_BIT_CM 9
`define RSC_BIT_ILL 14
`define RSC_BIT_TRAP 15
`define RSC_CAUSE_WMASK 16'hc2df
`define RSC_COLD_CLR 16'hc25c
`define RSC_CAUSE_RST 16'h0003
`define RSC_POWERUP_TIMER_SEL_RST 3'h7
`define RSC_CLKSEL_RST 3'h0
`define RSC_RESET_ADDR 24'h000000
`define RSC_ILLEGAL_OP 8'h3f
`define RSC_HARD_TRAP_LO 4'hd
`define RSC_HARD_TRAP_HI 4'hf
`define RSC_WREG_SP 15
`define RSC_CLK_KHZ 25000
`define RSC_BOR_EXT_US 100
`define RSC_BOR_EXT_CYC ((`RSC_BOR_EXT_US * `RSC_CLK_KHZ) / 1000)
`define RSC_PIN_MIN_NS 2000
`define RSC_PIN_MIN_CYC ((`RSC_PIN_MIN_NS * `RSC_CLK_KHZ + 999999) / 1000000)
`define RSC_POWERUP_TIMER_STEP_MS 1
`define RSC_POWERUP_TIMER_STEP_CYC (`RSC_POWERUP_TIMER_STEP_MS * `RSC_CLK_KHZ)
`endif

// ===== rsc_pkg.sv
// types shared by the reset source and cause logic
// assumes nothing beyond the standard language
`default_nettype none
package rsc_pkg;
  typedef enum logic [1:0] {SEQ_LOW, SEQ_BOR_EXT, SEQ_POWERUP_TIMER, SEQ_RUN} rsc_seq_type;
  typedef struct packed {
    rsc_seq_type seq;
    logic [31:0] cnt;
    logic hold;
    logic drop;
  } rsc_tmr_type;
  typedef struct packed {
    logic [7:0] cnt;
    logic rst;
  } rsc_flt_type;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] cause;
    logic [2:0] powerup_timer_sel;
    logic system_reset_n_n;
    logic cold;
    logic wake;
    logic [2:0] clksel;
    logic started;
    logic fetch_start;
    logic [23:0] start_addr;
    logic [14:0] wreg_init;
    logic [15:0] pps_shadow;
  } rsc_top_type;
endpackage : rsc_pkg
`default_nettype wire

// ===== rsc_pin_filter.sv
// glitch filter for the active-low external reset pin
// assumes the pin is already synchronous to clk_i
`include "rsc_regs.svh"
`default_nettype none
module rsc_pin_filter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and filtered reset
  input wire logic external_reset_pin_n_i,
  output logic pin_reset_o
);
  import rsc_pkg::*;
  rsc_flt_type st_ff;
  rsc_flt_type nxt_st;
  localparam logic [7:0] MIN_CYC = 8'(`RSC_PIN_MIN_CYC);

  always_comb begin
    nxt_st = st_ff;
    if (external_reset_pin_n_i) begin
      nxt_st.cnt = 8'h00;
      nxt_st.rst = 1'b0;
    end else begin
      // saturate so a long hold cannot wrap and release early
      if (st_ff.cnt != MIN_CYC) begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
      nxt_st.rst = (st_ff.cnt == MIN_CYC);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_reset_o = st_ff.rst;
endmodule : rsc_pin_filter
`default_nettype wire

// ===== rsc_powerup_timer.sv
// brown-out extension and programmable power-up delay sequencer
// assumes supply_ok_i is the comparator level, synchronous to clk_i
`include "rsc_regs.svh"
`default_nettype none
module rsc_powerup_timer #(
  parameter int unsigned POWERUP_TIMER_STEP_CYC = `RSC_POWERUP_TIMER_STEP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // supply monitor and delay select
  input wire logic supply_ok_i,
  input wire logic [2:0] powerup_delay_select_i,
  // hold and brown-out event
  output logic hold_o,
  output logic drop_o
);
  import rsc_pkg::*;
  rsc_tmr_type st_ff;
  rsc_tmr_type nxt_st;
  localparam logic [31:0] BOR_EXT_LAST = 32'(`RSC_BOR_EXT_CYC - 1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.drop = 1'b0;
    if (!supply_ok_i) begin
      // every dip restarts the whole extension from the top
      nxt_st.drop = (st_ff.seq != SEQ_LOW);
      nxt_st.seq = SEQ_LOW;
      nxt_st.cnt = 32'h0;
    end else begin
      case (st_ff.seq)
        SEQ_LOW: begin
          nxt_st.seq = SEQ_BOR_EXT;
          nxt_st.cnt = BOR_EXT_LAST;
        end
        SEQ_BOR_EXT: begin
          if (st_ff.cnt != 32'h0) begin
            nxt_st.cnt = st_ff.cnt - 32'h1;
          end else if (powerup_delay_select_i == 3'h0) begin
            nxt_st.seq = SEQ_RUN;
          end else begin
            nxt_st.seq = SEQ_POWERUP_TIMER;
            nxt_st.cnt = (32'(POWERUP_TIMER_STEP_CYC) << powerup_delay_select_i) - 32'h1;
          end
        end
        SEQ_POWERUP_TIMER: begin
          if (st_ff.cnt != 32'h0) begin
            nxt_st.cnt = st_ff.cnt - 32'h1;
          end else begin
            nxt_st.seq = SEQ_RUN;
          end
        end
        default: begin
          nxt_st.seq = SEQ_RUN;
        end
      endcase
    end
    nxt_st.hold = (nxt_st.seq != SEQ_RUN);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{seq: SEQ_LOW, cnt: 32'h0, hold: 1'b1, drop: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hold_o = st_ff.hold;
  assign drop_o = st_ff.drop;
endmodule : rsc_powerup_timer
`default_nettype wire

// ===== rsc_supply_model.sv
// model of the supply monitor and the board-level reset supervisor
// assumes the bench calls its tasks right after a rising edge of clk_i
`default_nettype none
module rsc_supply_model (
  // clock
  input wire logic clk_i,
  // supply level and reset pin
  output logic supply_ok_o,
  output logic external_reset_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    supply_ok_o = 1'b1;
    // no pull-up on the pin, so it is never left floating
    external_reset_pin_n_o = 1'b1;
  end

  // supply falls below threshold for n cycles
  task automatic dip(input int n);
    supply_ok_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    supply_ok_o <= 1'b1;
  endtask : dip

  // supervisor pulls the pin low for n cycles, then back to supply
  task automatic pin_low(input int n);
    external_reset_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    external_reset_pin_n_o <= 1'b1;
  endtask : pin_low
endmodule : rsc_supply_model
`default_nettype wire

// ===== rsc_reset_cause_bench.sv
// self-checking bench for the reset source and cause logic
// assumes rsc_supply_model drives the supply level and the reset pin
`default_nettype none
module rsc_reset_cause_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic supply_ok_i, external_reset_pin_n_i;
  logic reset_instr_i = 1'b0, wdt_timeout_i = 1'b0, sleep_mode_i = 1'b0;
  logic power_save_sleep_i = 1'b0, power_save_idle_i = 1'b0;
  logic watchdog_clear_instruction_i = 1'b0, trap_busy_i = 1'b0, trap_new_i = 1'b0;
  logic [3:0] trap_busy_level_i = 4'hf, trap_new_level_i = 4'hd, ptr_use_idx_i = 4'h3;
  logic fetch_valid_i = 1'b0, ptr_use_i = 1'b0, target_restricted_i = 1'b0;
  logic program_flow_change_i = 1'b0, vector_flow_change_i = 1'b0;
  logic idle_mode_i = 1'b0, wreg_write_i = 1'b0, pps_write_i = 1'b0;
  logic [3:0] wreg_write_idx_i = 4'h0;
  logic [15:0] pps_wdata_i = 16'h0000;
  logic [23:0] fetch_opcode_i = 24'h3f1234, start_addr_o;
  logic [15:0] pps_value_i = 16'h0000;
  logic [2:0] initial_clock_select_i = 3'h2, current_clock_select_o;
  logic clock_ready_i = 1'b1, system_reset_n_o, cold_reset_o, wake_o, fetch_start_o;
  logic [15:0] exp_tab [10] = '{16'h0040, 16'h0010, 16'h8000, 16'h0200, 16'h4000,
                                16'h4000, 16'h4000, 16'h4000, 16'h0008, 16'h0004};
  int miscompares = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;

  // short power-up step keeps the 128 ms setting to 512 cycles
  rsc_reset_cause #(.POWERUP_TIMER_STEP_CYC(4)) i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .supply_ok_i, .external_reset_pin_n_i, .reset_instr_i,
    .wdt_timeout_i, .sleep_mode_i, .idle_mode_i, .power_save_sleep_i,
    .power_save_idle_i, .watchdog_clear_instruction_i, .trap_busy_i, .trap_busy_level_i,
    .trap_new_i, .trap_new_level_i, .fetch_valid_i, .fetch_opcode_i,
    .wreg_write_i, .wreg_write_idx_i, .ptr_use_i, .ptr_use_idx_i,
    .program_flow_change_i, .vector_flow_change_i, .target_restricted_i,
    .pps_write_i, .pps_wdata_i, .pps_value_i, .initial_clock_select_i,
    .clock_ready_i, .system_reset_n_o, .cold_reset_o, .current_clock_select_o, .wake_o,
    .fetch_start_o, .start_addr_o
  );

  rsc_supply_model i_sup (
    .clk_i, .supply_ok_o(supply_ok_i), .external_reset_pin_n_o(external_reset_pin_n_i)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one classic cycle; called right after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  // looks at the reset output mid-cycle, ends aligned to a rising edge
  task automatic wait_srn(input logic lvl, input int lim);
    int n = 0;
    while (system_reset_n_o !== lvl) begin
      @(negedge clk_i);
      n++;
      if (n > lim) begin
        miscompares++;
        test_done();
      end
    end
    @(posedge clk_i);
  endtask : wait_srn

  task automatic fire(input int k);
    case (k)
      0: reset_instr_i <= 1'b1;
      1: wdt_timeout_i <= 1'b1;
      2: trap_new_i <= 1'b1;
      3: pps_value_i <= 16'h00ff;
      4: fetch_valid_i <= 1'b1;
      5: ptr_use_i <= 1'b1;
      6: program_flow_change_i <= 1'b1;
      7: vector_flow_change_i <= 1'b1;
      8: power_save_sleep_i <= 1'b1;
      default: power_save_idle_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {reset_instr_i, wdt_timeout_i, trap_new_i, fetch_valid_i, ptr_use_i} <= '0;
    {program_flow_change_i, vector_flow_change_i, power_save_sleep_i} <= '0;
    {power_save_idle_i, watchdog_clear_instruction_i} <= '0;
  endtask : fire

  initial begin
    int t0;
    int n;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cyc_cnt;
    @(negedge clk_i);
    chk("cold_out", {cold_reset_o, system_reset_n_o}, 2'b10);
    @(posedge clk_i);
    rd(8'h00, 32'h0003, "cause_por");
    rd(8'h04, 32'h0007, "powerup_timer_sel");
    rd(8'h0c, 32'h0, "unmapped");
    wait_srn(1'b1, 4000);
    n = cyc_cnt - t0;
    chk("powerup_timer_len", n >= 3012 && n <= 3022, 1);
    chk("clk_cold", current_clock_select_o, 3'h2);
    $display("test startup done");

    initial_clock_select_i <= 3'h5;
    trap_busy_i <= 1'b1;
    target_restricted_i <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      wr(8'h00, 32'h0);
      clock_ready_i <= 1'b0;
      fire(k);
      if (k < 8) begin
        wait_srn(1'b0, 6);
        wait_srn(1'b1, 3);
        clock_ready_i <= 1'b1;
        n = 0;
        while (fetch_start_o !== 1'b1 && n < 8) begin
          @(negedge clk_i);
          n++;
        end
        chk("fetch", {fetch_start_o, start_addr_o}, {1'b1, 24'h0});
        @(posedge clk_i);
      end
      rd(8'h00, {16'h0, exp_tab[k]}, "cause_evt");
      chk("clk_warm", current_clock_select_o, 3'h2);
    end
    {trap_busy_i, target_restricted_i, clock_ready_i} <= 3'b001;
    $display("test events done");

    sleep_mode_i <= 1'b1;
    fire(1);
    @(negedge clk_i);
    chk("wake", {wake_o, system_reset_n_o}, 2'b11);
    @(posedge clk_i);
    sleep_mode_i <= 1'b0;
    wr(8'h00, 32'h0010);
    chk("no_reset", system_reset_n_o, 1);
    watchdog_clear_instruction_i <= 1'b1;
    fire(8);
    rd(8'h00, 32'h0008, "wdt_clear");
    wr(8'h00, 32'hffff);
    rd(8'h00, 32'hc2df, "sw_set");
    chk("no_reset", system_reset_n_o, 1);
    wr(8'h00, 32'h0);
    // a written register used as pointer and a legal pin-select write stay quiet
    wreg_write_idx_i <= 4'h3;
    wreg_write_i <= 1'b1;
    @(posedge clk_i);
    wreg_write_i <= 1'b0;
    fire(5);
    pps_wdata_i <= 16'h00a5;
    pps_value_i <= 16'h00a5;
    pps_write_i <= 1'b1;
    @(posedge clk_i);
    pps_write_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("legal_use", system_reset_n_o, 1);
    rd(8'h00, 32'h0, "legal_flags");
    $display("test software done");

    i_sup.pin_low(20);
    rd(8'h00, 32'h0, "glitch");
    i_sup.pin_low(60);
    @(negedge clk_i);
    chk("pin_hold", system_reset_n_o, 0);
    wait_srn(1'b1, 8);
    rd(8'h00, 32'h0080, "pin_flag");
    $display("test pin done");

    wr(8'h00, 32'hc2dd);
    wr(8'h04, 32'h0);
    i_sup.dip(10);
    repeat (1000) @(posedge clk_i);
    chk("bor_hold", {system_reset_n_o, cold_reset_o}, 2'b01);
    i_sup.dip(5);
    t0 = cyc_cnt;
    wait_srn(1'b1, 3000);
    n = cyc_cnt - t0;
    chk("bor_len", n >= 2500 && n <= 2510, 1);
    rd(8'h00, 32'h0083, "bor_flags");
    chk("clk_bor", current_clock_select_o, 3'h5);
    $display("test brownout done");
    test_done();
  end
endmodule : rsc_reset_cause_bench
`default_nettype wire
